// ==== rtl/bas_top.v ====
// Two-axis brake sequencer, switch decoder and AXI4-Lite registers
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "bas_defines.vh"
module bas_top #(
   parameter CYC_PER_TICK = `BAS_CYC_PER_TICK,
   parameter DLY_W = `BAS_DLY_W
) (
   input wire CLK_SYS,
   input wire RST_N,
   input wire [4:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output wire S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output wire S_AXI_WREADY,
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [4:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output wire S_AXI_ARREADY,
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY,
   input wire SERVO_ON_A,
   input wire SERVO_ON_B,
   input wire ALARM_A,
   input wire ALARM_B,
   input wire FORCED_STOP_INPUT_N,
   input wire FORCED_STOP_CMD,
   input wire MAIN_POWER_OK,
   input wire [3:0] AXIS_NUMBER_SELECTOR,
   input wire TEST_MODE_SELECTOR,
   input wire FACTORY_SWITCH_UP,
   output wire BRAKE_INTERLOCK_FIRST_AXIS,
   output wire BRAKE_INTERLOCK_SECOND_AXIS,
   output wire DRIVE_ON_A,
   output wire DRIVE_ON_B,
   output reg [4:0] AXIS_NUM_A,
   output reg [4:0] AXIS_NUM_B,
   output reg AXIS_NUM_VALID,
   output reg [1:0] SWITCH_ERROR_CODE,
   output reg TEST_MODE,
   output reg NET_ENABLE,
   output reg DOWNSTREAM_NET_ENABLE,
   output wire IRQ
);
   localparam [31:0] TICK_LAST_W = CYC_PER_TICK - 1;
   localparam [14:0] TICK_LAST = TICK_LAST_W[14:0];

   // Millisecond tick shared by both axes
   reg [14:0] div_reg;
   reg tick_reg;
   always @(posedge CLK_SYS) begin
      if (!RST_N) begin
         div_reg <= 15'h0000;
         tick_reg <= 1'b0;
      end else if (div_reg == TICK_LAST) begin
         div_reg <= 15'h0000;
         tick_reg <= 1'b1;
      end else begin
         div_reg <= div_reg + 15'h0001;
         tick_reg <= 1'b0;
      end
   end

   // Software registers
   reg [DLY_W-1:0] delay_a_reg;
   reg [DLY_W-1:0] delay_b_reg;
   reg [`BAS_INT_W-1:0] int_stat_reg;
   reg [`BAS_INT_W-1:0] int_mask_reg;

   // Shared shutdown causes for both axes
   wire common_fault = !FORCED_STOP_INPUT_N | FORCED_STOP_CMD | !MAIN_POWER_OK;
   wire fault_a = common_fault | ALARM_A;
   wire fault_b = common_fault | ALARM_B;
   wire trip_a;
   wire trip_b;

   bas_axis_seq #(
      .DLY_W(DLY_W)
   ) u_axis_a (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .tick_ms(tick_reg),
      .servo_on(SERVO_ON_A),
      .fault(fault_a),
      .delay_ms(delay_a_reg),
      .brake_release(BRAKE_INTERLOCK_FIRST_AXIS),
      .drive_on(DRIVE_ON_A),
      .trip(trip_a)
   );

   bas_axis_seq #(
      .DLY_W(DLY_W)
   ) u_axis_b (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .tick_ms(tick_reg),
      .servo_on(SERVO_ON_B),
      .fault(fault_b),
      .delay_ms(delay_b_reg),
      .brake_release(BRAKE_INTERLOCK_SECOND_AXIS),
      .drive_on(DRIVE_ON_B),
      .trip(trip_b)
   );

   // Switch decode, selector only; cable order plays no part
   reg [1:0] err_next;
   reg sw_err_prev_reg;
   always @* begin
      err_next = `BAS_ERR_NONE;
      if (AXIS_NUMBER_SELECTOR == `BAS_SEL_BAD)
         err_next = `BAS_ERR_SEL_F;
      else if (FACTORY_SWITCH_UP)
         err_next = `BAS_ERR_RSVD;
   end

   always @(posedge CLK_SYS) begin
      if (!RST_N) begin
         AXIS_NUM_A <= 5'h00;
         AXIS_NUM_B <= 5'h00;
         AXIS_NUM_VALID <= 1'b0;
         SWITCH_ERROR_CODE <= `BAS_ERR_NONE;
         TEST_MODE <= 1'b0;
         NET_ENABLE <= 1'b0;
         DOWNSTREAM_NET_ENABLE <= 1'b0;
         sw_err_prev_reg <= 1'b0;
      end else begin
         SWITCH_ERROR_CODE <= err_next;
         // One cycle behind the code, so a new error shows as a single event
         sw_err_prev_reg <= (SWITCH_ERROR_CODE != `BAS_ERR_NONE);
         if (AXIS_NUMBER_SELECTOR == `BAS_SEL_BAD) begin
            AXIS_NUM_A <= 5'h00;
            AXIS_NUM_B <= 5'h00;
            AXIS_NUM_VALID <= 1'b0;
         end else begin
            // Both axes numbered, with or without a motor
            AXIS_NUM_A <= {1'b0, AXIS_NUMBER_SELECTOR} + 5'h01;
            AXIS_NUM_B <= {1'b0, AXIS_NUMBER_SELECTOR} + 5'h02;
            AXIS_NUM_VALID <= 1'b1;
         end
         TEST_MODE <= TEST_MODE_SELECTOR;
         // Blocks our own link and everything chained after us
         NET_ENABLE <= !TEST_MODE_SELECTOR;
         DOWNSTREAM_NET_ENABLE <= !TEST_MODE_SELECTOR;
      end
   end

   wire sw_err_rise = (SWITCH_ERROR_CODE != `BAS_ERR_NONE) & !sw_err_prev_reg;

   // AXI4-Lite write path: address and data taken in either order
   reg aw_held_reg;
   reg [4:0] aw_addr_reg;
   reg w_held_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;

   assign S_AXI_AWREADY = !aw_held_reg & !S_AXI_BVALID;
   assign S_AXI_WREADY = !w_held_reg & !S_AXI_BVALID;

   wire aw_fire = S_AXI_AWVALID & S_AXI_AWREADY;
   wire w_fire = S_AXI_WVALID & S_AXI_WREADY;
   wire aw_have = aw_held_reg | aw_fire;
   wire w_have = w_held_reg | w_fire;
   wire [4:0] wr_addr = aw_held_reg ? aw_addr_reg : S_AXI_AWADDR;
   wire [31:0] wr_data = w_held_reg ? w_data_reg : S_AXI_WDATA;
   wire [3:0] wr_strb = w_held_reg ? w_strb_reg : S_AXI_WSTRB;
   wire wr_go = aw_have & w_have & !S_AXI_BVALID;

   wire wr_dly_a = wr_go & (wr_addr == `BAS_OFS_DELAY_A);
   wire wr_dly_b = wr_go & (wr_addr == `BAS_OFS_DELAY_B);
   wire wr_istat = wr_go & (wr_addr == `BAS_OFS_INT_STAT);
   wire wr_imask = wr_go & (wr_addr == `BAS_OFS_INT_MASK);
   wire wr_stat = wr_go & (wr_addr == `BAS_OFS_STATUS);
   wire wr_hit = wr_dly_a | wr_dly_b | wr_istat | wr_imask | wr_stat;

   always @(posedge CLK_SYS) begin
      if (!RST_N) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 5'h00;
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `BAS_RESP_OKAY;
      end else begin
         if (wr_go) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_hit ? `BAS_RESP_OKAY : `BAS_RESP_DECERR;
         end else begin
            if (aw_fire) begin
               aw_held_reg <= 1'b1;
               aw_addr_reg <= S_AXI_AWADDR;
            end
            if (w_fire) begin
               w_held_reg <= 1'b1;
               w_data_reg <= S_AXI_WDATA;
               w_strb_reg <= S_AXI_WSTRB;
            end
            if (S_AXI_BVALID && S_AXI_BREADY)
               S_AXI_BVALID <= 1'b0;
         end
      end
   end

   // Delay registers honour byte lanes 0 and 1
   always @(posedge CLK_SYS) begin
      if (!RST_N) begin
         delay_a_reg <= `BAS_DELAY_RST;
         delay_b_reg <= `BAS_DELAY_RST;
         int_mask_reg <= `BAS_MASK_RST;
      end else begin
         if (wr_dly_a && wr_strb[0])
            delay_a_reg[7:0] <= wr_data[7:0];
         if (wr_dly_a && wr_strb[1])
            delay_a_reg[15:8] <= wr_data[15:8];
         if (wr_dly_b && wr_strb[0])
            delay_b_reg[7:0] <= wr_data[7:0];
         if (wr_dly_b && wr_strb[1])
            delay_b_reg[15:8] <= wr_data[15:8];
         if (wr_imask && wr_strb[0])
            int_mask_reg <= wr_data[`BAS_INT_W-1:0];
      end
   end

   // Sticky events; a new event beats a same-cycle clear
   wire [`BAS_INT_W-1:0] int_set = {trip_b, trip_a, sw_err_rise};
   wire [`BAS_INT_W-1:0] int_clr =
      (wr_istat && wr_strb[0]) ? wr_data[`BAS_INT_W-1:0] : {`BAS_INT_W{1'b0}};
   always @(posedge CLK_SYS) begin
      if (!RST_N)
         int_stat_reg <= {`BAS_INT_W{1'b0}};
      else
         int_stat_reg <= (int_stat_reg & ~int_clr) | int_set;
   end

   assign IRQ = |(int_stat_reg & int_mask_reg);

   // AXI4-Lite read path, one read at a time
   reg [31:0] rd_mux;
   assign S_AXI_ARREADY = !S_AXI_RVALID;
   wire ar_fire = S_AXI_ARVALID & S_AXI_ARREADY;

   wire [31:0] status_word = {
      13'h0,
      NET_ENABLE,
      TEST_MODE,
      SWITCH_ERROR_CODE,
      AXIS_NUM_VALID,
      AXIS_NUM_B,
      AXIS_NUM_A,
      DRIVE_ON_B,
      BRAKE_INTERLOCK_SECOND_AXIS,
      DRIVE_ON_A,
      BRAKE_INTERLOCK_FIRST_AXIS
   };

   always @* begin
      rd_mux = 32'h00000000;
      case (S_AXI_ARADDR)
         `BAS_OFS_DELAY_A: rd_mux = {16'h0000, delay_a_reg};
         `BAS_OFS_DELAY_B: rd_mux = {16'h0000, delay_b_reg};
         `BAS_OFS_STATUS: rd_mux = status_word;
         `BAS_OFS_INT_STAT: rd_mux = {29'h0, int_stat_reg};
         `BAS_OFS_INT_MASK: rd_mux = {29'h0, int_mask_reg};
         default: rd_mux = 32'h00000000;
      endcase
   end

   wire rd_hit = (S_AXI_ARADDR == `BAS_OFS_DELAY_A) |
                 (S_AXI_ARADDR == `BAS_OFS_DELAY_B) |
                 (S_AXI_ARADDR == `BAS_OFS_STATUS) |
                 (S_AXI_ARADDR == `BAS_OFS_INT_STAT) |
                 (S_AXI_ARADDR == `BAS_OFS_INT_MASK);

   always @(posedge CLK_SYS) begin
      if (!RST_N) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h00000000;
         S_AXI_RRESP <= `BAS_RESP_OKAY;
      end else if (ar_fire) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= rd_mux;
         S_AXI_RRESP <= rd_hit ? `BAS_RESP_OKAY : `BAS_RESP_DECERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end
endmodule // bas_top
`default_nettype wire

// ==== rtl/bas_defines.vh ====
// Constants for the brake and axis sequencer
// Functional notes
// - Each brake interlock output is high while the brake is released and low while engaged.
// - On servo-off the interlock drops at once and the drive stage stops after the delay.
// - The servo-off delay comes from a per-axis brake delay parameter written by software.
// - Selector value n from 0 to E gives axis n+1 to the first axis and n+2 to the second.
// - Selector value F assigns no axis numbers and raises switch error code 1.
// - The factory switch found up raises switch error code 2.
// - Test mode blocks network traffic for this amplifier and all downstream ones.
// - Test mode is entered only with the test switch up; down is normal operation.
// - Both axes get numbers even when one runs without a motor.
// - Numbering depends only on the selector, never on the chain position.
`ifndef BAS_DEFINES_VH
`define BAS_DEFINES_VH
`define BAS_CLK_KHZ 25000
`define BAS_TICK_MS 1
`define BAS_CYC_PER_TICK (`BAS_TICK_MS * `BAS_CLK_KHZ)
`define BAS_DLY_W 16
`define BAS_OFS_DELAY_A 5'h00
`define BAS_OFS_DELAY_B 5'h04
`define BAS_OFS_STATUS 5'h08
`define BAS_OFS_INT_STAT 5'h0C
`define BAS_OFS_INT_MASK 5'h10
`define BAS_DELAY_RST 16'h0000
`define BAS_MASK_RST 3'h0
`define BAS_INT_SWERR 0
`define BAS_INT_TRIP_A 1
`define BAS_INT_TRIP_B 2
`define BAS_INT_W 3
`define BAS_ERR_NONE 2'h0
`define BAS_ERR_SEL_F 2'h1
`define BAS_ERR_RSVD 2'h2
`define BAS_SEL_BAD 4'hF
`define BAS_RESP_OKAY 2'h0
`define BAS_RESP_DECERR 2'h3
`endif

// ==== rtl/bas_axis_seq.v ====
// One axis brake interlock and drive stage sequencer
`timescale 1ns/1ps
`default_nettype none
`include "bas_defines.vh"
module bas_axis_seq #(
   parameter DLY_W = `BAS_DLY_W
) (
   input wire clk,
   input wire rst_n,
   input wire tick_ms,
   input wire servo_on,
   input wire fault,
   input wire [DLY_W-1:0] delay_ms,
   output wire brake_release,
   output wire drive_on,
   output reg trip
);
   localparam [2:0] ST_OFF = 3'h1;
   localparam [2:0] ST_RUN = 3'h2;
   localparam [2:0] ST_DLY = 3'h4;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [DLY_W-1:0] cnt_reg;
   reg [DLY_W-1:0] cnt_next;

   always @* begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      trip = 1'b0;
      case (state_reg)
         ST_OFF: begin
            if (servo_on && !fault)
               state_next = ST_RUN;
         end
         ST_RUN: begin
            if (fault) begin
               state_next = ST_OFF;
               trip = 1'b1;
            end else if (!servo_on) begin
               // Delay counted in ms ticks from the software value
               state_next = ST_DLY;
               cnt_next = delay_ms;
            end
         end
         ST_DLY: begin
            if (fault) begin
               state_next = ST_OFF;
               trip = 1'b1;
            end else if (cnt_reg == {DLY_W{1'b0}}) begin
               state_next = ST_OFF;
            end else if (tick_ms) begin
               cnt_next = cnt_reg - {{(DLY_W-1){1'b0}}, 1'b1};
            end
         end
         default: state_next = ST_OFF;
      endcase
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= ST_OFF;
         cnt_reg <= {DLY_W{1'b0}};
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // On servo-off the brake drops first so the load is held before the drive lets go; on a fault both drop together
   assign brake_release = state_reg[1];
   assign drive_on = state_reg[1] | state_reg[2];
endmodule // bas_axis_seq
`default_nettype wire

// ==== sim/bas_checker.sv ====
// Port assertions for the brake and axis sequencer
`timescale 1ns/1ps
`default_nettype none
module bas_checker (
   input wire CLK_SYS,
   input wire RST_N,
   input wire SERVO_ON_A,
   input wire ALARM_A,
   input wire FORCED_STOP_INPUT_N,
   input wire FORCED_STOP_CMD,
   input wire MAIN_POWER_OK,
   input wire [3:0] AXIS_NUMBER_SELECTOR,
   input wire TEST_MODE_SELECTOR,
   input wire FACTORY_SWITCH_UP,
   input wire BRAKE_INTERLOCK_FIRST_AXIS,
   input wire DRIVE_ON_A,
   input wire [4:0] AXIS_NUM_A,
   input wire [4:0] AXIS_NUM_B,
   input wire AXIS_NUM_VALID,
   input wire [1:0] SWITCH_ERROR_CODE,
   input wire TEST_MODE,
   input wire NET_ENABLE,
   input wire DOWNSTREAM_NET_ENABLE
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   wire fa = ALARM_A || !FORCED_STOP_INPUT_N || FORCED_STOP_CMD || !MAIN_POWER_OK;
   wire sf = AXIS_NUMBER_SELECTOR == 4'hF;
   logic [4:0] sq_reg;
   always @(posedge CLK_SYS) sq_reg <= {1'b0, AXIS_NUMBER_SELECTOR};
   a_brk_needs_on: assert property ($rose(BRAKE_INTERLOCK_FIRST_AXIS) |-> $past(SERVO_ON_A && !fa))
      else $error("brake released without servo-on");
   a_brk_off_drop: assert property (!SERVO_ON_A |=> !BRAKE_INTERLOCK_FIRST_AXIS)
      else $error("brake still released after servo-off");
   a_drv_hold_on: assert property (BRAKE_INTERLOCK_FIRST_AXIS && !SERVO_ON_A && !fa |=> DRIVE_ON_A)
      else $error("drive dropped together with the brake");
   a_drv_off_bound: assert property ($fell(BRAKE_INTERLOCK_FIRST_AXIS) |-> ##[0:300] !DRIVE_ON_A)
      else $error("drive never shut off");
   a_fault_off: assert property (fa |=> !BRAKE_INTERLOCK_FIRST_AXIS && !DRIVE_ON_A)
      else $error("fault left axis running");
   a_axis_num: assert property (!sf |=> AXIS_NUM_VALID && AXIS_NUM_A == sq_reg + 5'h01 && AXIS_NUM_B == sq_reg + 5'h02)
      else $error("wrong axis numbers");
   a_sel_f_err: assert property (sf |=> !AXIS_NUM_VALID && SWITCH_ERROR_CODE == 2'h1 && AXIS_NUM_A == 5'h00)
      else $error("selector F accepted");
   a_rsvd_err: assert property (!sf |=> SWITCH_ERROR_CODE == ($past(FACTORY_SWITCH_UP) ? 2'h2 : 2'h0))
      else $error("wrong factory switch error");
   a_test_block: assert property (TEST_MODE_SELECTOR |=> TEST_MODE && !NET_ENABLE && !DOWNSTREAM_NET_ENABLE)
      else $error("network open in test mode");
   a_test_only: assert property (!TEST_MODE_SELECTOR |=> !TEST_MODE)
      else $error("test mode with switch down");
   c_drive_off: cover property ($fell(DRIVE_ON_A));
   c_sel_f: cover property (sf ##1 !sf);
   c_fault_run: cover property (fa && BRAKE_INTERLOCK_FIRST_AXIS);
endmodule // bas_checker
`default_nettype wire

// ==== sim/bas_ctrl_model.sv ====
// Motion controller model driving servo-on for both axes
`timescale 1ns/1ps
`default_nettype none
module bas_ctrl_model #(
   parameter int RELAY_CYC = 3,
   parameter int STOP_CYC = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] want_on,
   input wire logic [1:0] brake_rel,
   output logic [1:0] servo_on,
   output logic [1:0] moving
);
   int cnt [2];
   always @(posedge clk) begin
      for (int i = 0; i < 2; i++) begin
         if (!rst_n || (!want_on[i] && !servo_on[i])) begin
            servo_on[i] <= 1'b0;
            moving[i] <= 1'b0;
            cnt[i] <= 0;
         end else if (want_on[i]) begin
            servo_on[i] <= 1'b1;
            cnt[i] <= brake_rel[i] ? cnt[i] + 1 : 0;
            moving[i] <= brake_rel[i] && cnt[i] >= RELAY_CYC;
         end else begin
            moving[i] <= 1'b0;
            cnt[i] <= moving[i] ? 0 : cnt[i] + 1;
            // Stand still first, else the load coasts under a closing brake
            if (!moving[i] && cnt[i] >= STOP_CYC) servo_on[i] <= 1'b0;
         end
      end
   end
endmodule // bas_ctrl_model
`default_nettype wire

// ==== sim/bas_bench.sv ====
// Self-checking bench for the brake and axis sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
   $display("BAD %0t got %h want %h", $time, g, e); end end
module bas_bench;
   localparam int TICK = 4;
   logic clk = 1'b0, rst_n = 1'b0;
   logic [4:0] awaddr = 5'h00, araddr = 5'h00;
   logic [31:0] wdata = 32'h00000000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire awready, wready, bvalid, arready, rvalid, irq;
   wire [1:0] bresp, rresp, err, srv, moving;
   wire [31:0] rdata;
   logic [1:0] want = 2'h0;
   logic alarm_a = 1'b0, alarm_b = 1'b0, fs_n = 1'b1, fs_cmd = 1'b0, pwr = 1'b1;
   logic [3:0] sel = 4'h0;
   logic tsel = 1'b0, fact = 1'b0;
   wire brk_a, brk_b, drv_a, drv_b, nvld, tmode, net, dnet;
   wire [4:0] num_a, num_b;
   int n_mismatch = 0, comparisons = 0, cyc = 0, seed = 32'h0524CE4F, n, d, lo;
   logic [31:0] rd;
   logic [1:0] rsp;
   always #20 clk = ~clk;
   bas_top #(.CYC_PER_TICK(TICK)) dut (.CLK_SYS(clk), .RST_N(rst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .SERVO_ON_A(srv[0]), .SERVO_ON_B(srv[1]), .ALARM_A(alarm_a), .ALARM_B(alarm_b),
      .FORCED_STOP_INPUT_N(fs_n), .FORCED_STOP_CMD(fs_cmd), .MAIN_POWER_OK(pwr),
      .AXIS_NUMBER_SELECTOR(sel), .TEST_MODE_SELECTOR(tsel), .FACTORY_SWITCH_UP(fact),
      .BRAKE_INTERLOCK_FIRST_AXIS(brk_a), .BRAKE_INTERLOCK_SECOND_AXIS(brk_b),
      .DRIVE_ON_A(drv_a), .DRIVE_ON_B(drv_b), .AXIS_NUM_A(num_a), .AXIS_NUM_B(num_b),
      .AXIS_NUM_VALID(nvld), .SWITCH_ERROR_CODE(err), .TEST_MODE(tmode),
      .NET_ENABLE(net), .DOWNSTREAM_NET_ENABLE(dnet), .IRQ(irq));
   bas_ctrl_model #(.RELAY_CYC(3), .STOP_CYC(2)) ctrl (.clk(clk), .rst_n(rst_n),
      .want_on(want), .brake_rel({brk_b, brk_a}), .servo_on(srv), .moving(moving));
   function automatic logic [10:0] exp_num(input logic [3:0] s);
      if (s == 4'hF) return 11'h000;
      return {1'b1, 5'(s) + 5'h01, 5'(s) + 5'h02};
   endfunction
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic bus_wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      rsp = bresp;
      bready <= 1'b0;
   endtask
   task automatic bus_rd(input logic [4:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask
   // Whole run is a few hundred cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         if (i != 2) begin
            bus_rd(5'(i * 4));
            `CHK(rd, 32'h00000000)
            `CHK(rsp, (i == 5) ? 2'h3 : 2'h0)
         end
      end
      bus_wr(5'h18, 32'h00000001);
      `CHK(rsp, 2'h3)
      $display("register test done");
      for (int i = 0; i < 24; i++) begin
         @(posedge clk);
         sel <= (i < 16) ? 4'(i) : 4'($random(seed));
         fact <= (i > 19);
         tsel <= 1'($random(seed));
         repeat (3) @(posedge clk);
         `CHK({nvld, num_a, num_b}, exp_num(sel))
         `CHK(!nvld || (num_a != num_b), 1'b1)
         `CHK(err, (sel == 4'hF) ? 2'h1 : {fact, 1'b0})
         `CHK({tmode, net, dnet}, tsel ? 3'h4 : 3'h3)
      end
      sel <= 4'h2;
      fact <= 1'b0;
      tsel <= 1'b0;
      $display("switch test done");
      for (int k = 0; k < 4; k++) begin
         d = (k == 0) ? 0 : 1 + {$random(seed)} % 3;
         lo = (d == 0) ? 2 : (d - 1) * TICK + 1;
         bus_wr(5'h00, 32'(d));
         bus_wr(5'h04, 32'(d));
         want <= 2'h3;
         do @(posedge clk); while (!moving[0]);
         `CHK({brk_a, drv_a, brk_b, drv_b}, 4'hF)
         want <= 2'h0;
         do @(posedge clk); while (srv[0]);
         n = 0;
         do begin
            @(posedge clk);
            n++;
            if (n == 1) `CHK({brk_a, brk_b}, 2'h0)
         end while (drv_a);
         `CHK(drv_b, 1'b0)
         `CHK(n >= lo && n <= d * TICK + 2, 1'b1)
         repeat (3) @(posedge clk);
      end
      $display("brake test done");
      bus_rd(5'h0C);
      `CHK(rd[0], 1'b1)
      `CHK(irq, 1'b0)
      bus_wr(5'h10, 32'h00000007);
      `CHK(irq, 1'b1)
      bus_wr(5'h0C, 32'h00000007);
      `CHK(irq, 1'b0)
      for (int f = 0; f < 5; f++) begin
         want <= 2'h3;
         do @(posedge clk); while (!(brk_a && brk_b));
         alarm_a <= (f == 0);
         alarm_b <= (f == 4);
         fs_n <= (f != 1);
         fs_cmd <= (f == 2);
         pwr <= (f != 3);
         repeat (3) @(posedge clk);
         `CHK({brk_a, drv_a, brk_b, drv_b}, {f == 4, f == 4, f == 0, f == 0})
         `CHK(irq, 1'b1)
         bus_rd(5'h0C);
         `CHK(rd, (f == 0) ? 32'h2 : (f == 4) ? 32'h4 : 32'h6)
         want <= 2'h0;
         repeat (20) @(posedge clk);
         alarm_a <= 1'b0;
         alarm_b <= 1'b0;
         fs_n <= 1'b1;
         fs_cmd <= 1'b0;
         pwr <= 1'b1;
         bus_wr(5'h0C, 32'h00000006);
         bus_rd(5'h0C);
         `CHK(rd, 32'h00000000)
         `CHK(irq, 1'b0)
      end
      $display("fault test done");
      stop_test();
   end
endmodule // bas_bench
bind bas_top bas_checker chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .SERVO_ON_A(SERVO_ON_A),
   .ALARM_A(ALARM_A), .FORCED_STOP_INPUT_N(FORCED_STOP_INPUT_N),
   .FORCED_STOP_CMD(FORCED_STOP_CMD), .MAIN_POWER_OK(MAIN_POWER_OK),
   .AXIS_NUMBER_SELECTOR(AXIS_NUMBER_SELECTOR), .TEST_MODE_SELECTOR(TEST_MODE_SELECTOR),
   .FACTORY_SWITCH_UP(FACTORY_SWITCH_UP), .BRAKE_INTERLOCK_FIRST_AXIS(BRAKE_INTERLOCK_FIRST_AXIS),
   .DRIVE_ON_A(DRIVE_ON_A), .AXIS_NUM_A(AXIS_NUM_A), .AXIS_NUM_B(AXIS_NUM_B),
   .AXIS_NUM_VALID(AXIS_NUM_VALID), .SWITCH_ERROR_CODE(SWITCH_ERROR_CODE),
   .TEST_MODE(TEST_MODE), .NET_ENABLE(NET_ENABLE), .DOWNSTREAM_NET_ENABLE(DOWNSTREAM_NET_ENABLE));
`default_nettype wire
